// ===== pkg/vdc_pkg.sv
// Shared constants, types and helpers for the dummy-cycle descriptor link.
// Assumes both ends run on one clock, hclk, and import this package whole.
package vdc_pkg;
    // Descriptor field positions.
    localparam int DESC_SUPPORT_BIT = 31;
    localparam int DESC_WIDTH_LSB = 29;
    localparam int DESC_ACCESS_BIT = 28;
    localparam int DESC_BYTE1_BIT = 27;
    localparam int DESC_LSB_POS_LSB = 24;
    localparam int DESC_LOCAL_LSB = 16;
    localparam int DESC_FLAG_8D8D8D = 23;
    localparam int DESC_FLAG_8S8S8S = 22;
    localparam int DESC_FLAG_4S4D4D = 21;
    localparam int DESC_FLAG_4S4S4S = 20;
    localparam int DESC_RD_OP_LSB = 8;
    localparam int DESC_WR_OP_LSB = 0;
    // Link command codes and timing.
    localparam logic [7:0] PARAM_READ_OP = 8'h5A;
    localparam logic [7:0] OP_NONE = 8'h00;
    localparam logic [3:0] PARAM_DUMMY_CYCLES = 4'h8;
    localparam logic [3:0] NO_DUMMY = 4'h0;
    localparam logic [7:0] SETTING_RESET = 8'h00;
    localparam int SETTING_BITS = 8;
    // Host register map, byte offsets on the bus.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] DESC_OFS = 8'h08;
    localparam logic [7:0] DATA_OFS = 8'h0C;
    localparam logic [7:0] ADDR_OFS = 8'h10;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_MODE_LSB = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_ERR_BIT = 2;
    localparam int STAT_VALID_BIT = 3;

    typedef enum logic [2:0] {
        M_1S1S1S = 3'h0,
        M_4S4S4S = 3'h1,
        M_4S4D4D = 3'h2,
        M_8S8S8S = 3'h3,
        M_8D8D8D = 3'h4
    } mode_t;

    typedef enum logic [1:0] {
        OP_FETCH = 2'h0,
        OP_READ = 2'h1,
        OP_WRITE = 2'h2
    } host_op_t;

    // Local register address taken from byte 0 or byte 1 of a link address.
    function automatic logic [7:0] local_addr_of(input logic [31:0] addr, input logic byte1);
        local_addr_of = byte1 ? addr[15:8] : addr[7:0];
    endfunction

    // Base address with the local register address laid into byte 0 or byte 1.
    function automatic logic [31:0] place_local_addr(input logic [31:0] base, input logic [7:0] loc,
                                                     input logic byte1);
        place_local_addr = byte1 ? {base[31:16], loc, base[7:0]} : {base[31:8], loc};
    endfunction

    // Whether the descriptor flags a mode for the direct command.
    function automatic logic mode_flagged(input logic [31:0] desc, input mode_t mode);
        case (mode)
            M_8D8D8D: mode_flagged = desc[DESC_FLAG_8D8D8D];
            M_8S8S8S: mode_flagged = desc[DESC_FLAG_8S8S8S];
            M_4S4D4D: mode_flagged = desc[DESC_FLAG_4S4D4D];
            M_4S4S4S: mode_flagged = desc[DESC_FLAG_4S4S4S];
            default: mode_flagged = 1'b0;
        endcase
    endfunction
endpackage

// ===== pkg/vdc_link_if.sv
// Word-level command link between the host controller and the memory device.
// Assumes both ends share hclk; the bench instantiates and connects it.
`timescale 1ns/1ps
interface vdc_link_if;
    import vdc_pkg::*;
    logic req;
    logic [7:0] opcode;
    logic [31:0] addr;
    mode_t mode;
    logic [7:0] wdata;
    logic ack;
    logic err;
    logic [31:0] rdata;

    modport host (output req, output opcode, output addr, output mode, output wdata,
                  input ack, input err, input rdata);
    modport dev (input req, input opcode, input addr, input mode, input wdata,
                 output ack, output err, output rdata);
endinterface

// ===== core/wait_counter.sv
// Down-counter that spaces out the dummy cycles before a device answer.
// Assumes load is a one-cycle strobe from logic on hclk.
`timescale 1ns/1ps
module wait_counter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic load,
    input wire logic [3:0] count,
    output logic expired
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // Load wins over the running count so a new command restarts cleanly.
    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = count;
        end else if (cnt_reg != 4'h0) begin
            cnt_next = cnt_reg - 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= 4'h0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
        end
    end

    assign expired = (cnt_reg == 4'h0);
endmodule // wait_counter

// ===== core/vdc_device.sv
// Memory-device end: presents the dummy-cycle descriptor and the setting register.
// Assumes the host keeps req high until it has seen ack, on the same clock.
`timescale 1ns/1ps
module vdc_device
    import vdc_pkg::*;
#(
    parameter logic SUPPORTED = 1'b1,
    parameter logic [1:0] WIDTH_CODE = 2'h2,
    parameter logic ADDRESSED = 1'b0,
    parameter logic ADDR_IN_BYTE1 = 1'b0,
    parameter logic [2:0] FIELD_LSB = 3'h3,
    parameter logic [7:0] LOCAL_ADDR = 8'h00,
    parameter logic [3:0] MODE_FLAGS = 4'hA,
    parameter logic [3:0] DIRECT_DUMMY = 4'h8,
    parameter logic [3:0] ALT_DUMMY = 4'hA,
    parameter logic [7:0] RD_OP = 8'h85,
    parameter logic [7:0] WR_OP = 8'h81
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    vdc_link_if.dev link,
    output logic [7:0] setting,
    output logic [4:0] dummy_field
);
    // A field that runs past the top of the register cannot be described, so support reads 0.
    localparam logic FIELD_FITS = (int'(FIELD_LSB) + int'(WIDTH_CODE) + 2) <= SETTING_BITS;
    localparam logic [31:0] DESC = {SUPPORTED & FIELD_FITS, WIDTH_CODE, ADDRESSED, ADDR_IN_BYTE1,
                                    FIELD_LSB,
                                    ADDRESSED ? LOCAL_ADDR : {MODE_FLAGS, DIRECT_DUMMY},
                                    RD_OP, WR_OP};
    // Width code 0 means two bits and 3 means five, so shift a five-bit mask down by the missing bits.
    localparam logic [4:0] FIELD_MASK = 5'h1F >> (2'h3 - WIDTH_CODE);

    typedef enum logic [1:0] {
        D_IDLE = 2'h0,
        D_WAIT = 2'h1,
        D_ANS = 2'h3,
        D_REST = 2'h2
    } dev_state_t;

    dev_state_t state_reg, state_next;
    logic [7:0] set_reg, set_next;
    logic [31:0] resp_reg, resp_next;
    logic err_reg, err_next;
    logic load;
    logic [3:0] load_count;
    logic expired;
    logic addr_ok;
    logic cmd_ok;
    logic [3:0] direct_wait;

    wait_counter i_wait_counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .load(load),
        .count(load_count),
        .expired(expired)
    );

    // Addressed commands must hit the local register in the advertised byte lane.
    assign addr_ok = !ADDRESSED || (local_addr_of(link.addr, ADDR_IN_BYTE1) == LOCAL_ADDR);
    assign cmd_ok = DESC[DESC_SUPPORT_BIT] && addr_ok;
    // Single-lane mode and addressed builds never wait; flagged modes use the advertised count, others their own.
    always_comb begin
        if (ADDRESSED || link.mode == M_1S1S1S) begin
            direct_wait = NO_DUMMY;
        end else if (mode_flagged(DESC, link.mode)) begin
            direct_wait = DIRECT_DUMMY;
        end else begin
            direct_wait = ALT_DUMMY;
        end
    end

    // Command decode, dummy wait and answer sequencing.
    always_comb begin
        state_next = state_reg;
        set_next = set_reg;
        resp_next = resp_reg;
        err_next = err_reg;
        load = 1'b0;
        load_count = NO_DUMMY;
        unique case (state_reg)
            D_IDLE: begin
                if (link.req) begin
                    state_next = D_WAIT;
                    load = 1'b1;
                    err_next = 1'b0;
                    resp_next = 32'h0000_0000;
                    if (link.opcode == PARAM_READ_OP) begin
                        load_count = PARAM_DUMMY_CYCLES;
                        resp_next = DESC;
                    end else if (link.opcode == RD_OP && RD_OP != OP_NONE && cmd_ok) begin
                        load_count = direct_wait;
                        resp_next = {24'h00_0000, set_reg};
                    end else if (link.opcode == WR_OP && WR_OP != OP_NONE && cmd_ok) begin
                        set_next = link.wdata;
                    end else begin
                        err_next = 1'b1;
                    end
                end
            end
            D_WAIT: begin
                if (expired) begin
                    state_next = D_ANS;
                end
            end
            D_ANS: begin
                state_next = D_REST;
            end
            D_REST: begin
                if (!link.req) begin
                    state_next = D_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= D_IDLE;
            set_reg <= SETTING_RESET;
            resp_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            set_reg <= set_next;
            resp_reg <= resp_next;
            err_reg <= err_next;
        end
    end

    assign link.ack = (state_reg == D_ANS);
    assign link.rdata = resp_reg;
    assign link.err = err_reg;
    assign setting = set_reg;
    // The field is contiguous from its least significant bit upward.
    assign dummy_field = 5'(set_reg >> FIELD_LSB) & FIELD_MASK;
endmodule // vdc_device

// ===== core/vdc_host.sv
// Host controller end: software orders a descriptor fetch or a setting access over AHB-Lite.
// Assumes a single AHB-Lite master, single word transfers, and the device end on the link.
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
module vdc_host
    import vdc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    vdc_link_if.host link
);
    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_REQ = 2'h1
    } host_state_t;

    host_state_t state_reg, state_next;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_ofs_reg, wr_ofs_next;
    logic [31:0] hrdata_reg, hrdata_next;
    host_op_t op_reg, op_next;
    mode_t mode_reg, mode_next;
    logic [31:0] base_reg, base_next;
    logic [7:0] data_reg, data_next;
    logic [31:0] desc_reg, desc_next;
    logic valid_reg, valid_next;
    logic done_reg, done_next;
    logic err_reg, err_next;
    logic req_reg, req_next;
    logic [7:0] opc_reg, opc_next;
    logic [31:0] laddr_reg, laddr_next;
    mode_t lmode_reg, lmode_next;
    logic [7:0] lwdata_reg, lwdata_next;
    logic ap_take;
    logic start;
    logic [31:0] status_word;
    logic [31:0] rd_mux;
    logic usable;

    // An address phase is taken only for a selected, active transfer while the bus is ready.
    assign ap_take = hsel && htrans[1] && hready;
    assign start = wr_pend_reg && wr_ofs_reg == CTRL_OFS && hwdata[CTRL_START_BIT] && state_reg == H_IDLE;
    assign status_word = {28'h000_0000, valid_reg, err_reg, done_reg, state_reg == H_REQ};

    // Read data is registered at the address phase, so it stands for the whole data phase.
    always_comb begin
        case (haddr[7:0])
            CTRL_OFS: rd_mux = {26'h000_0000, mode_reg, op_reg, 1'b0};
            STATUS_OFS: rd_mux = status_word;
            DESC_OFS: rd_mux = desc_reg;
            DATA_OFS: rd_mux = {24'h00_0000, data_reg};
            ADDR_OFS: rd_mux = base_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // The descriptor is only trusted once fetched and only while it reports support.
    assign usable = valid_reg && desc_reg[DESC_SUPPORT_BIT];

    // Bus slave: address phase capture and register writes in the data phase.
    always_comb begin
        wr_pend_next = ap_take && hwrite;
        wr_ofs_next = ap_take ? haddr[7:0] : wr_ofs_reg;
        hrdata_next = (ap_take && !hwrite) ? rd_mux : hrdata_reg;
        op_next = op_reg;
        mode_next = mode_reg;
        base_next = base_reg;
        data_next = data_reg;
        if (wr_pend_reg) begin
            case (wr_ofs_reg)
                CTRL_OFS: begin
                    if (state_reg == H_IDLE) begin
                        op_next = host_op_t'(hwdata[CTRL_OP_LSB +: 2]);
                        mode_next = mode_t'(hwdata[CTRL_MODE_LSB +: 3]);
                    end
                end
                DATA_OFS: data_next = hwdata[7:0];
                ADDR_OFS: base_next = hwdata;
                default: ;
            endcase
        end
        // A finished read overrides a software write to the data register.
        if (state_reg == H_REQ && link.ack && !link.err && op_reg == OP_READ) begin
            data_next = link.rdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_ofs_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
            op_reg <= OP_FETCH;
            mode_reg <= M_1S1S1S;
            base_reg <= 32'h0000_0000;
            data_reg <= 8'h00;
        end else if (ce) begin
            wr_pend_reg <= wr_pend_next;
            wr_ofs_reg <= wr_ofs_next;
            hrdata_reg <= hrdata_next;
            op_reg <= op_next;
            mode_reg <= mode_next;
            base_reg <= base_next;
            data_reg <= data_next;
        end
    end

    // Command sequencer: issues at most one link command per start and records its outcome.
    always_comb begin
        state_next = state_reg;
        desc_next = desc_reg;
        valid_next = valid_reg;
        done_next = done_reg;
        err_next = err_reg;
        req_next = req_reg;
        opc_next = opc_reg;
        laddr_next = laddr_reg;
        lmode_next = lmode_reg;
        lwdata_next = lwdata_reg;
        unique case (state_reg)
            H_IDLE: begin
                if (start) begin
                    done_next = 1'b0;
                    err_next = 1'b0;
                    lmode_next = mode_t'(hwdata[CTRL_MODE_LSB +: 3]);
                    lwdata_next = data_reg;
                    if (host_op_t'(hwdata[CTRL_OP_LSB +: 2]) == OP_FETCH) begin
                        opc_next = PARAM_READ_OP;
                        laddr_next = 32'h0000_0000;
                        req_next = 1'b1;
                        state_next = H_REQ;
                    end else if (!usable || hwdata[CTRL_OP_LSB +: 2] == 2'h3) begin
                        done_next = 1'b1;
                        err_next = 1'b1;
                    end else begin
                        // The op register is written this same edge; decode from the bus word.
                        opc_next = (hwdata[CTRL_OP_LSB +: 2] == 2'h1) ? desc_reg[DESC_RD_OP_LSB +: 8]
                                                                      : desc_reg[DESC_WR_OP_LSB +: 8];
                        laddr_next = desc_reg[DESC_ACCESS_BIT]
                            ? place_local_addr(base_reg, desc_reg[DESC_LOCAL_LSB +: 8],
                                               desc_reg[DESC_BYTE1_BIT])
                            : 32'h0000_0000;
                        req_next = 1'b1;
                        state_next = H_REQ;
                    end
                end
            end
            H_REQ: begin
                // A zero opcode is never sent; it ends at once as an error.
                if (opc_reg == OP_NONE) begin
                    req_next = 1'b0;
                    done_next = 1'b1;
                    err_next = 1'b1;
                    state_next = H_IDLE;
                end else if (link.ack) begin
                    req_next = 1'b0;
                    done_next = 1'b1;
                    err_next = link.err;
                    if (op_reg == OP_FETCH) begin
                        desc_next = link.rdata;
                        valid_next = !link.err;
                    end
                    state_next = H_IDLE;
                end
            end
            // Codes 2 and 3 are unused; fall back to idle should one ever appear.
            default: state_next = H_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= H_IDLE;
            desc_reg <= 32'h0000_0000;
            valid_reg <= 1'b0;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            req_reg <= 1'b0;
            opc_reg <= 8'h00;
            laddr_reg <= 32'h0000_0000;
            lmode_reg <= M_1S1S1S;
            lwdata_reg <= 8'h00;
        end else if (ce) begin
            state_reg <= state_next;
            desc_reg <= desc_next;
            valid_reg <= valid_next;
            done_reg <= done_next;
            err_reg <= err_next;
            req_reg <= req_next;
            opc_reg <= opc_next;
            laddr_reg <= laddr_next;
            lmode_reg <= lmode_next;
            lwdata_reg <= lwdata_next;
        end
    end

    // The slave never inserts wait states and never signals an error response.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign link.req = req_reg && opc_reg != OP_NONE;
    assign link.opcode = opc_reg;
    assign link.addr = laddr_reg;
    assign link.mode = lmode_reg;
    assign link.wdata = lwdata_reg;
endmodule // vdc_host

// ===== bench/vdc_checker.sv
// Link checker: handshake rules and answer latencies of the descriptor link.
// Assumes the device is built with the default flags 4'hA, dummy 8, alternate 10.
`timescale 1ns/1ps
module vdc_checker
    import vdc_pkg::*;
#(
    parameter logic [31:0] EXP_DESC = 32'h0,
    parameter logic [7:0] RD_OP = 8'h85,
    parameter logic [7:0] WR_OP = 8'h81
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req,
    input wire logic [7:0] opcode,
    input wire logic [31:0] addr,
    input wire mode_t mode,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic err,
    input wire logic [31:0] rdata
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // A fetch waits out eight dummy cycles before the answer.
    property p_fetch_lat; $rose(req) && opcode == PARAM_READ_OP |-> !ack [*8] ##1 !ack [*2] ##1 ack; endproperty
    a_fetch_lat: assert property (p_fetch_lat) else $error("fetch answer late or early");
    // The single-lane direct read takes no dummy cycles.
    property p_rd_1s; $rose(req) && opcode == RD_OP && mode == M_1S1S1S |-> !ack [*2] ##1 ack; endproperty
    a_rd_1s: assert property (p_rd_1s) else $error("single-lane read used dummy cycles");
    // Flagged modes use the advertised count.
    property p_rd_flag;
        $rose(req) && opcode == RD_OP && (mode == M_8D8D8D || mode == M_4S4D4D) |-> !ack [*8] ##1 !ack [*2] ##1 ack;
    endproperty
    a_rd_flag: assert property (p_rd_flag) else $error("flagged mode count wrong");
    // Unflagged modes still answer, with another count.
    property p_rd_alt;
        $rose(req) && opcode == RD_OP && (mode == M_8S8S8S || mode == M_4S4S4S) |-> !ack [*8] ##1 !ack [*4] ##1 ack;
    endproperty
    a_rd_alt: assert property (p_rd_alt) else $error("unflagged mode not served");
    property p_wr_lat; $rose(req) && opcode == WR_OP |-> !ack [*2] ##1 ack; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer timing wrong");
    // The fetched word is the device's descriptor, with no error.
    property p_desc_val; ack && opcode == PARAM_READ_OP |-> !err && rdata == EXP_DESC; endproperty
    a_desc_val: assert property (p_desc_val) else $error("descriptor word wrong");
    property p_rd_byte; ack && opcode == RD_OP |-> !err && rdata[31:8] == 24'h0; endproperty
    a_rd_byte: assert property (p_rd_byte) else $error("setting read not a clean byte");
    property p_ack_pulse; ack |=> !ack && !req; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a pulse or req kept");
    // The host must not change a command while it is outstanding.
    property p_req_hold; req && !ack |=> req && $stable(opcode) && $stable(mode) && $stable(wdata); endproperty
    a_req_hold: assert property (p_req_hold) else $error("command changed while outstanding");
    // In this direct-access build neither the fetch nor a setting access carries an address.
    property p_addr_direct; req |-> addr == 32'h0000_0000; endproperty
    a_addr_direct: assert property (p_addr_direct) else $error("direct command carried an address");
endmodule // vdc_checker

// ===== bench/tb_volatile_dummy_cycle_descriptor.sv
// Testbench: host and device joined by the link, driven over AHB-Lite from the host side.
// Assumes zero-wait-state slave; expected values come from the device parameters set here.
`timescale 1ns/1ps
module tb_volatile_dummy_cycle_descriptor;
    import vdc_pkg::*;
    localparam logic [2:0] LSB = 3'h3;
    localparam logic [3:0] FLAGS = 4'hA;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, st;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] setting, b;
    logic [4:0] dummy_field;
    logic [31:0] seed = 32'hE7A5032C;
    int n_fail = 0, checks_done = 0, cyc = 0;

    // Descriptor expected from the device build settings.
    function automatic logic [31:0] desc_of(input logic [2:0] lsb, input logic [3:0] fl);
        return {1'b1, 2'h2, 1'b0, 1'b0, lsb, fl, 4'h8, 8'h85, 8'h81};
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    vdc_link_if link ();
    vdc_host i_vdc_host (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .link(link.host));
    vdc_device #(.FIELD_LSB(LSB), .MODE_FLAGS(FLAGS)) i_vdc_device (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .link(link.dev), .setting(setting), .dummy_field(dummy_field));
    vdc_checker #(.EXP_DESC(desc_of(LSB, FLAGS))) i_vdc_checker (.hclk(hclk), .hresetn(hresetn), .req(link.req),
        .opcode(link.opcode), .addr(link.addr), .mode(link.mode), .wdata(link.wdata), .ack(link.ack),
        .err(link.err), .rdata(link.rdata));

    initial begin
        forever #10 hclk = ~hclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One single transfer; the slave's hreadyout is the bus ready.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask

    // Starts an order and polls until done; the final status is returned.
    task automatic run(input logic [1:0] op, input logic [2:0] m, output logic [31:0] s);
        ahb(1'b1, CTRL_OFS, {26'h0, m, op, 1'b1}, s);
        for (int i = 0; i < 40; i++) begin
            ahb(1'b0, STATUS_OFS, 32'h0, s);
            if (s[STAT_DONE_BIT] === 1'b1) break;
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // A hang ends the run with a mismatch counted.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Before any fetch, a setting read is refused and the descriptor is empty.
        run(2'h1, 3'h0, st);
        chk(st, 32'h0000_0006);
        chk({31'h0, hresp}, 32'h0000_0000);
        ahb(1'b0, DESC_OFS, 32'h0, rd);
        chk(rd, 32'h0);
        ahb(1'b0, 8'h1C, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test refusal done");
        run(2'h0, 3'h0, st);
        chk(st, 32'h0000_000A);
        ahb(1'b0, DESC_OFS, 32'h0, rd);
        chk(rd, desc_of(LSB, FLAGS));
        $display("test fetch done");
        // Codes 0 to 4 in bits 5:3 reach the host as modes 0, 0, 1, 1 and 2, each with a random setting byte written then read back.
        for (int m = 0; m < 5; m++) begin
            seed = xs(seed);
            b = seed[7:0];
            ahb(1'b1, DATA_OFS, {24'h0, b}, rd);
            run(2'h2, m[2:0], st);
            chk(st, 32'h0000_000A);
            chk({24'h0, setting}, {24'h0, b});
            chk({27'h0, dummy_field}, {28'h0, b[LSB +: 4]});
            ahb(1'b1, DATA_OFS, {24'h0, ~b}, rd);
            run(2'h1, m[2:0], st);
            chk(st, 32'h0000_000A);
            ahb(1'b0, DATA_OFS, 32'h0, rd);
            chk(rd, {24'h0, b});
        end
        $display("test modes done");
        run(2'h3, 3'h0, st);
        chk(st, 32'h0000_000E);
        // The refused order is still recorded in the control register; start reads back as 0.
        ahb(1'b0, CTRL_OFS, 32'h0, rd);
        chk(rd, 32'h0000_0006);
        $display("test bad order done");
        end_of_test();
    end
endmodule // tb_volatile_dummy_cycle_descriptor
